// ### core/pack_status_pkg.sv
// Purpose: Shared constants for the pack status readout and config EEPROM port
// Assumes: 100 MHz mclk
// Notes:   Command codes, status bit positions and EEPROM timing
package pack_status_pkg;

    // ***********************************************
    // Clock and timing
    // ***********************************************
    localparam int CLK_PERIOD_NS = 10;
    // EEPROM two-wire clock: longest bit time, quarter of it per phase
    localparam int EE_BIT_PERIOD_NS = 10000;
    localparam int EE_QTR_CYCLES = (EE_BIT_PERIOD_NS / 4) / CLK_PERIOD_NS;
    // Least time the EEPROM supply is on before the first clock edge
    localparam int EE_SETTLE_NS = 1000;
    localparam int EE_SETTLE_CYCLES = (EE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ***********************************************
    // Command codes
    // ***********************************************
    localparam logic [7:0] CMD_PACK_STATUS = 8'h2F;
    localparam logic [7:0] CMD_CELL_FOUR = 8'h3C;
    localparam logic [7:0] CMD_CELL_THREE = 8'h3D;
    localparam logic [7:0] CMD_CELL_TWO = 8'h3E;
    localparam logic [7:0] CMD_CELL_ONE = 8'h3F;

    // ***********************************************
    // Status byte bit positions
    // ***********************************************
    localparam int BIT_OFS_CANCEL = 7;
    localparam int BIT_END_VOLT2 = 6;
    localparam int BIT_ACTIVITY = 5;
    localparam int BIT_DSG_QUAL = 4;
    localparam int BIT_CHG_PIN = 3;
    localparam int BIT_DSG_PIN = 2;
    localparam int BIT_OVER = 1;
    localparam int BIT_UNDER = 0;

    // ***********************************************
    // EEPROM layout and reset values
    // ***********************************************
    localparam logic [7:0] EE_PACK_CONFIG_ADDR = 8'h3F;
    localparam logic [6:0] EE_DEV_ADDR = 7'h50;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] PACK_CONFIG_RESET = 8'h00;
    localparam logic [15:0] CELL_RESET = 16'h0000;

    typedef enum logic [2:0] {
        EE_IDLE,
        EE_SETTLE,
        EE_START,
        EE_BIT,
        EE_STOP
    } ee_state_type;

endpackage : pack_status_pkg

// ### core/pack_status_eeprom_config.sv
// Purpose: Pack status word, cell voltage readout and config EEPROM master
// Assumes: Measurement results arrive on mclk; EEPROM data pin is asynchronous
// Notes:   Command answers one cycle after the request
`timescale 1ns/100ps
`default_nettype none

// Contract
// - Status command returns word, flags in low byte
// - Bit 7 set once offset calibration done
// - Bit 6 set when voltage at/below threshold
// - Bit 5 set when converter saw pulse
// - Bit 4 shows discharge cycle qualification
// - Bit 3 mirrors charge control pin level
// - Bit 2 mirrors discharge control pin level
// - Bit 1 set on cell, pack or temperature
// - Over-limit flag not latched, follows live state
// - Bit 0 set when any cell below limit
// - Under-limit flag only for lithium packs
// - Under-limit flag not latched, tracks live state
// - High byte is EEPROM pack configuration byte
// - Cell commands: lowest code cell four
// - EEPROM accessed only on full reset, history
// - Access powers supply, uses clock, data pins
module pack_status_eeprom_config
    import pack_status_pkg::*;
#(
    parameter int CELLS = 4,
    parameter int SETTLE_CYCLES = EE_SETTLE_CYCLES
) (
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic ce,
    // Measurement results
    input wire logic meas_tick,
    input wire logic ofs_cal_done,
    input wire logic [15:0] pack_mv,
    input wire logic [15:0] end_voltage_second_flag_threshold_mv,
    input wire logic [15:0] pack_ov_threshold_mv,
    input wire logic charge_pulse,
    input wire logic discharge_cycle_qualified,
    input wire logic charge_control_output,
    input wire logic discharge_control_output,
    input wire logic over_temp,
    input wire logic lithium_pack,
    input wire logic [15:0] cell_high_limit_mv,
    input wire logic [15:0] cell_low_limit_mv,
    input wire logic [15:0] cell_voltage_input [CELLS],
    // Host command port
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    output logic resp_valid,
    output logic resp_hit,
    output logic [15:0] resp_data,
    // EEPROM requests
    input wire logic full_reset_req,
    input wire logic history_req,
    input wire logic [7:0] history_addr,
    input wire logic [7:0] history_data,
    output logic ee_busy,
    output logic ee_nack,
    // EEPROM pins
    output logic eeprom_supply_on,
    output logic eeprom_clock_pin,
    input wire logic eeprom_data_pin_in,
    output logic eeprom_data_pin_out,
    output logic eeprom_data_pin_oe_b
);

    // ***********************************************
    // Live status flags
    // ***********************************************
    logic [7:0] status_reg, status_next;
    logic ofs_cancel_reg, ofs_cancel_next;
    logic activity_acc_reg, activity_acc_next;
    logic [15:0] cell_reg [CELLS];
    logic [CELLS-1:0] cell_high, cell_low;
    logic over_any, under_any;
    logic [7:0] pack_config_reg;

    genvar gi;
    generate
        for (gi = 0; gi < CELLS; gi++) begin : g_cell
            assign cell_high[gi] = cell_voltage_input[gi] > cell_high_limit_mv;
            assign cell_low[gi] = cell_voltage_input[gi] < cell_low_limit_mv;
            always_ff @(posedge mclk or negedge rst_b) begin
                if (!rst_b) begin
                    cell_reg[gi] <= CELL_RESET;
                end else if (ce && meas_tick) begin
                    cell_reg[gi] <= cell_voltage_input[gi];
                end
            end
        end
    endgenerate

    assign over_any = (|cell_high) || (pack_mv > pack_ov_threshold_mv) || over_temp;
    assign under_any = lithium_pack && (|cell_low);

    always_comb begin
        status_next = status_reg;
        ofs_cancel_next = ofs_cancel_reg || ofs_cal_done;
        activity_acc_next = activity_acc_reg || charge_pulse;
        if (full_reset_req && !ee_busy) begin
            ofs_cancel_next = ofs_cal_done;
        end
        if (meas_tick) begin
            status_next[BIT_OFS_CANCEL] = ofs_cancel_next;
            status_next[BIT_END_VOLT2] = pack_mv <= end_voltage_second_flag_threshold_mv;
            status_next[BIT_ACTIVITY] = activity_acc_reg || charge_pulse;
            status_next[BIT_DSG_QUAL] = discharge_cycle_qualified;
            status_next[BIT_CHG_PIN] = charge_control_output;
            status_next[BIT_DSG_PIN] = discharge_control_output;
            status_next[BIT_OVER] = over_any;
            status_next[BIT_UNDER] = under_any;
            // A tick-cycle pulse is reported now; the next window starts empty
            activity_acc_next = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            status_reg <= STATUS_RESET;
            ofs_cancel_reg <= 1'b0;
            activity_acc_reg <= 1'b0;
        end else if (ce) begin
            status_reg <= status_next;
            ofs_cancel_reg <= ofs_cancel_next;
            activity_acc_reg <= activity_acc_next;
        end
    end

    // ***********************************************
    // Command answers
    // ***********************************************
    logic resp_valid_next, resp_hit_next;
    logic [15:0] resp_data_next;

    always_comb begin
        resp_valid_next = cmd_valid;
        resp_hit_next = 1'b0;
        resp_data_next = 16'h0000;
        if (cmd_valid) begin
            case (cmd_code)
                CMD_PACK_STATUS: begin
                    resp_hit_next = 1'b1;
                    resp_data_next = {pack_config_reg, status_reg};
                end
                CMD_CELL_FOUR, CMD_CELL_THREE, CMD_CELL_TWO, CMD_CELL_ONE: begin
                    resp_hit_next = 1'b1;
                    // Lowest code answers the highest cell
                    resp_data_next = cell_reg[2'(CMD_CELL_ONE - cmd_code)];
                end
                default: begin
                    resp_hit_next = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            resp_valid <= 1'b0;
            resp_hit <= 1'b0;
            resp_data <= 16'h0000;
        end else if (ce) begin
            resp_valid <= resp_valid_next;
            resp_hit <= resp_hit_next;
            resp_data <= resp_data_next;
        end
    end

    // ***********************************************
    // EEPROM two-wire master
    // ***********************************************
    ee_state_type state_reg, state_next;
    logic op_write_reg, op_write_next;
    logic [1:0] byte_idx_reg, byte_idx_next;
    logic [3:0] bit_idx_reg, bit_idx_next;
    logic [1:0] phase_reg, phase_next;
    logic [15:0] tick_cnt_reg, tick_cnt_next;
    logic [7:0] shift_reg, shift_next;
    logic [7:0] word_addr_reg, word_addr_next;
    logic [7:0] wdata_reg, wdata_next;
    logic [7:0] pack_config_next;
    logic scl_reg, scl_next, sda_reg, sda_next, supply_reg, supply_next;
    logic nack_reg, nack_next;
    logic sda_meta_reg, sda_sync_reg;
    logic tick, last_byte;

    function automatic logic [7:0] byte_for(input logic [1:0] idx, input logic wr,
                                             input logic [7:0] waddr,
                                             input logic [7:0] wdat);
        logic [7:0] b;
        b = 8'hFF;
        case (idx)
            2'd0: b = {EE_DEV_ADDR, 1'b0};
            2'd1: b = waddr;
            2'd2: b = wr ? wdat : {EE_DEV_ADDR, 1'b1};
            default: b = 8'hFF;
        endcase
        return b;
    endfunction : byte_for

    assign tick = tick_cnt_reg == 16'(EE_QTR_CYCLES - 1);
    assign last_byte = op_write_reg ? (byte_idx_reg == 2'd2) : (byte_idx_reg == 2'd3);

    always_comb begin
        state_next = state_reg;
        op_write_next = op_write_reg;
        byte_idx_next = byte_idx_reg;
        bit_idx_next = bit_idx_reg;
        phase_next = phase_reg;
        tick_cnt_next = tick ? 16'h0000 : 16'(tick_cnt_reg + 16'h0001);
        shift_next = shift_reg;
        word_addr_next = word_addr_reg;
        wdata_next = wdata_reg;
        pack_config_next = pack_config_reg;
        scl_next = scl_reg;
        sda_next = sda_reg;
        supply_next = supply_reg;
        nack_next = nack_reg;
        case (state_reg)
            EE_IDLE: begin
                tick_cnt_next = 16'h0000;
                scl_next = 1'b1;
                sda_next = 1'b1;
                if (full_reset_req || history_req) begin
                    state_next = EE_SETTLE;
                    supply_next = 1'b1;
                    op_write_next = !full_reset_req;
                    word_addr_next = full_reset_req ? EE_PACK_CONFIG_ADDR : history_addr;
                    wdata_next = history_data;
                    byte_idx_next = 2'd0;
                    phase_next = 2'd0;
                    nack_next = 1'b0;
                end
            end
            EE_SETTLE: begin
                if (tick_cnt_reg == 16'(SETTLE_CYCLES - 1)) begin
                    state_next = EE_START;
                    tick_cnt_next = 16'h0000;
                end
            end
            EE_START: begin
                if (tick) begin
                    phase_next = 2'(phase_reg + 2'd1);
                    case (phase_reg)
                        2'd0: sda_next = 1'b1;
                        2'd1: scl_next = 1'b1;
                        2'd2: sda_next = 1'b0;
                        default: begin
                            scl_next = 1'b0;
                            state_next = EE_BIT;
                            bit_idx_next = 4'd0;
                            shift_next = byte_for(byte_idx_reg, op_write_reg,
                                                  word_addr_reg, wdata_reg);
                        end
                    endcase
                end
            end
            EE_BIT: begin
                if (tick) begin
                    phase_next = 2'(phase_reg + 2'd1);
                    case (phase_reg)
                        // Acknowledge slot is released; on the read byte it is the NACK
                        2'd0: sda_next = (bit_idx_reg < 4'd8) ? shift_reg[7] : 1'b1;
                        2'd1: scl_next = 1'b1;
                        2'd2: begin
                            if (bit_idx_reg < 4'd8) begin
                                shift_next = {shift_reg[6:0], sda_sync_reg};
                            end else if (byte_idx_reg != 2'd3 && sda_sync_reg) begin
                                nack_next = 1'b1;
                            end
                        end
                        default: begin
                            scl_next = 1'b0;
                            bit_idx_next = 4'(bit_idx_reg + 4'd1);
                            if (bit_idx_reg == 4'd8) begin
                                bit_idx_next = 4'd0;
                                byte_idx_next = 2'(byte_idx_reg + 2'd1);
                                shift_next = byte_for(2'(byte_idx_reg + 2'd1), op_write_reg,
                                                      word_addr_reg, wdata_reg);
                                if (!op_write_reg && byte_idx_reg == 2'd3) begin
                                    pack_config_next = shift_reg;
                                end
                                if (last_byte || nack_reg) begin
                                    state_next = EE_STOP;
                                end else if (!op_write_reg && byte_idx_reg == 2'd1) begin
                                    state_next = EE_START;
                                end
                            end
                        end
                    endcase
                end
            end
            EE_STOP: begin
                if (tick) begin
                    phase_next = 2'(phase_reg + 2'd1);
                    case (phase_reg)
                        2'd0: sda_next = 1'b0;
                        2'd1: scl_next = 1'b1;
                        2'd2: sda_next = 1'b1;
                        default: begin
                            state_next = EE_IDLE;
                            supply_next = 1'b0;
                        end
                    endcase
                end
            end
            default: begin
                state_next = EE_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= EE_IDLE;
            op_write_reg <= 1'b0;
            byte_idx_reg <= 2'd0;
            bit_idx_reg <= 4'd0;
            phase_reg <= 2'd0;
            tick_cnt_reg <= 16'h0000;
            shift_reg <= 8'hFF;
            word_addr_reg <= 8'h00;
            wdata_reg <= 8'h00;
            pack_config_reg <= PACK_CONFIG_RESET;
            scl_reg <= 1'b1;
            sda_reg <= 1'b1;
            supply_reg <= 1'b0;
            nack_reg <= 1'b0;
            sda_meta_reg <= 1'b1;
            sda_sync_reg <= 1'b1;
        end else if (ce) begin
            state_reg <= state_next;
            op_write_reg <= op_write_next;
            byte_idx_reg <= byte_idx_next;
            bit_idx_reg <= bit_idx_next;
            phase_reg <= phase_next;
            tick_cnt_reg <= tick_cnt_next;
            shift_reg <= shift_next;
            word_addr_reg <= word_addr_next;
            wdata_reg <= wdata_next;
            pack_config_reg <= pack_config_next;
            scl_reg <= scl_next;
            sda_reg <= sda_next;
            supply_reg <= supply_next;
            nack_reg <= nack_next;
            sda_meta_reg <= eeprom_data_pin_in;
            sda_sync_reg <= sda_meta_reg;
        end
    end

    assign ee_busy = state_reg != EE_IDLE;
    assign ee_nack = nack_reg;
    assign eeprom_supply_on = supply_reg;
    assign eeprom_clock_pin = scl_reg;
    assign eeprom_data_pin_out = sda_reg;
    assign eeprom_data_pin_oe_b = sda_reg;

    // ***********************************************
    // Checks
    // ***********************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    sequence ee_launch;
        ce && !ee_busy && (full_reset_req || history_req);
    endsequence
    sequence ee_powered;
        eeprom_supply_on && ee_busy;
    endsequence

    status_word_a: assert property (
        ce && cmd_valid && cmd_code == CMD_PACK_STATUS
        |=> resp_valid && resp_hit && resp_data == {$past(pack_config_reg), $past(status_reg)})
        else $error("status word answer wrong");
    cell_order_a: assert property (
        ce && cmd_valid && cmd_code == CMD_CELL_FOUR |=> resp_data == $past(cell_reg[3]))
        else $error("cell four not on lowest code");
    ofs_cancel_a: assert property (
        ce && $rose(status_reg[BIT_OFS_CANCEL]) |-> $past(ofs_cancel_next))
        else $error("offset cancel set without calibration");
    end_volt_a: assert property (
        ce && meas_tick |=> status_reg[BIT_END_VOLT2] == ($past(pack_mv) <= $past(end_voltage_second_flag_threshold_mv)))
        else $error("end voltage flag wrong");
    activity_a: assert property (
        ce && meas_tick && charge_pulse |=> status_reg[BIT_ACTIVITY])
        else $error("activity lost");
    pin_mirror_a: assert property (
        ce && meas_tick |=> status_reg[BIT_CHG_PIN] == $past(charge_control_output)
            && status_reg[BIT_DSG_PIN] == $past(discharge_control_output))
        else $error("control pin mirror wrong");
    over_clear_a: assert property (
        ce && meas_tick && !over_any |=> !status_reg[BIT_OVER])
        else $error("over flag latched");
    under_lith_a: assert property (
        ce && meas_tick && !lithium_pack |=> !status_reg[BIT_UNDER])
        else $error("under flag on non lithium pack");
    ee_power_a: assert property (
        ee_launch |=> ee_powered ##1 (ee_busy [*8]))
        else $error("EEPROM access not powered");
    ee_idle_a: assert property (
        !ee_busy |-> !eeprom_supply_on && eeprom_clock_pin && eeprom_data_pin_oe_b)
        else $error("EEPROM pins active outside access");

endmodule : pack_status_eeprom_config

`default_nettype wire

// ### sim/ee_partner_model.sv
// Purpose: Behavioural two-wire configuration EEPROM
// Assumes: Data line pulled up; master moves data only while clock low
// Notes: no_ack makes it leave every byte unacknowledged
`timescale 1ns/100ps
`default_nettype none
module ee_partner_model #(
    parameter logic [7:0] PACK_CFG = 8'hA5
) (
    // Two-wire pins
    input wire logic clock_line,
    input wire logic data_line,
    output logic data_low,
    // Fault control
    input wire logic no_ack
);
    logic [7:0] mem [256];
    logic [7:0] sr;
    logic [7:0] addr;
    logic rd = 1'b0;
    int bits = 0;
    int bytes = 0;
    initial begin
        data_low = 1'b0;
        mem[8'h11] = 8'h00;
        mem[8'h3F] = PACK_CFG;
    end
    // Start: data falls while clock is high
    always @(negedge data_line) begin
        if (clock_line === 1'b1) begin
            bits = 0;
            bytes = 0;
            rd = 1'b0;
            data_low <= 1'b0;
        end
    end
    always @(posedge clock_line) begin
        if (bits < 8) sr = {sr[6:0], data_line};
        bits = bits + 1;
    end
    // Acknowledge slot, then read data MSB first
    always @(negedge clock_line) begin
        if (bits == 8) begin
            data_low <= !no_ack && (bytes == 0 || !rd);
            if (bytes == 0) rd = sr[0];
            if (bytes == 1 && !rd) addr = sr;
            if (bytes == 2 && !rd) mem[addr] = sr;
            bytes = bytes + 1;
        end else if (bits == 9) begin
            bits = 0;
            data_low <= rd && bytes == 1 && !mem[addr][7];
        end else if (rd && bytes == 1 && bits < 8) begin
            data_low <= !mem[addr][7 - bits];
        end
    end
endmodule : ee_partner_model
`default_nettype wire

// ### sim/tb.sv
// Purpose: Self-checking bench for the pack status block
// Assumes: ce low only in the freeze step; EEPROM data line pulled up
// Notes: Status flags are set through encoded input vectors
`timescale 1ns/100ps
`default_nettype none
module tb
    import pack_status_pkg::*;
;
    logic mclk = 1'b0, rst_b = 1'b0, meas_tick = 1'b0, ofs_cal_done = 1'b0;
    logic charge_pulse = 1'b0, dsg_qual = 1'b0, chg_out = 1'b0, dsg_out = 1'b0;
    logic over_temp = 1'b0, lithium_pack = 1'b0, cmd_valid = 1'b0, no_ack = 1'b0;
    logic full_reset_req = 1'b0, history_req = 1'b0, ce = 1'b1;
    logic [15:0] pack_mv = 16'h0000, cells [4] = '{16'h07D0, 16'h07D1, 16'h07D0, 16'h07D3};
    logic [7:0] cmd_code = 8'h00, history_addr = 8'h00, history_data = 8'h00;
    logic [7:0] cfg_exp = PACK_CONFIG_RESET;
    logic resp_valid, resp_hit, ee_busy, ee_nack, supply, scl, d_out, d_oe_b, d_low;
    logic [15:0] resp_data;
    wire logic data_wire;
    int bad_count = 0, comparisons = 0, cycles = 0;

    assign data_wire = d_oe_b & ~d_low;
    always #(CLK_PERIOD_NS / 2) mclk = ~mclk;

    pack_status_eeprom_config #(.SETTLE_CYCLES(2)) u_pack_status_eeprom_config (
        .mclk(mclk), .rst_b(rst_b), .ce(ce), .meas_tick(meas_tick),
        .ofs_cal_done(ofs_cal_done), .pack_mv(pack_mv), .end_voltage_second_flag_threshold_mv(16'h0FA0),
        .pack_ov_threshold_mv(16'h2328), .charge_pulse(charge_pulse),
        .discharge_cycle_qualified(dsg_qual), .charge_control_output(chg_out),
        .discharge_control_output(dsg_out), .over_temp(over_temp),
        .lithium_pack(lithium_pack), .cell_high_limit_mv(16'h0BB8),
        .cell_low_limit_mv(16'h05DC), .cell_voltage_input(cells), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .resp_valid(resp_valid), .resp_hit(resp_hit),
        .resp_data(resp_data), .full_reset_req(full_reset_req), .history_req(history_req),
        .history_addr(history_addr), .history_data(history_data), .ee_busy(ee_busy),
        .ee_nack(ee_nack), .eeprom_supply_on(supply), .eeprom_clock_pin(scl),
        .eeprom_data_pin_in(data_wire), .eeprom_data_pin_out(d_out),
        .eeprom_data_pin_oe_b(d_oe_b));

    ee_partner_model u_ee_partner_model (
        .clock_line(scl), .data_line(data_wire), .data_low(d_low), .no_ack(no_ack));

    // *****
    // Tasks
    // *****
    task automatic check_word(input string what, input logic [15:0] exp, got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check_word

    task automatic end_sim();
        $display("Comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic read_cmd(input logic [7:0] code, input logic [15:0] exp, input logic hit);
        @(posedge mclk);
        cmd_valid <= 1'b1;
        cmd_code <= code;
        @(posedge mclk);
        cmd_valid <= 1'b0;
        #1;
        check_word("resp_valid", 16'h0001, {15'h0000, resp_valid});
        check_word("resp_hit", {15'h0000, hit}, {15'h0000, resp_hit});
        check_word("resp_data", exp, resp_data);
    endtask : read_cmd

    // Flags f: b7 cal, b5 pulse, b4 qual, b3 chg, b2 dsg, b1 temp, b0 lithium
    task automatic meas(input logic [15:0] pk, c1, c3, input logic [7:0] f, exp);
        @(posedge mclk);
        pack_mv <= pk;
        cells[0] <= c1;
        cells[2] <= c3;
        {ofs_cal_done, charge_pulse, dsg_qual, chg_out, dsg_out, over_temp} <= {f[7], f[5:1]};
        lithium_pack <= f[0];
        meas_tick <= 1'b1;
        @(posedge mclk);
        meas_tick <= 1'b0;
        charge_pulse <= 1'b0;
        read_cmd(CMD_PACK_STATUS, {cfg_exp, exp}, 1'b1);
    endtask : meas

    task automatic wait_idle();
        int n;
        n = 0;
        @(posedge mclk);
        #1;
        check_word("ee_busy", 16'h0001, {15'h0000, ee_busy});
        while (ee_busy === 1'b1 && n < 45000) begin
            @(posedge mclk);
            #1;
            n++;
        end
        check_word("ee_done", 16'h0000, {15'h0000, ee_busy});
    endtask : wait_idle

    task automatic ee_write(input logic [7:0] a, d, input logic nak);
        @(posedge mclk);
        no_ack <= nak;
        history_addr <= a;
        history_data <= d;
        history_req <= 1'b1;
        @(posedge mclk);
        history_req <= 1'b0;
        wait_idle();
        check_word("ee_nack", {15'h0000, nak}, {15'h0000, ee_nack});
    endtask : ee_write

    // *****
    // Monitors
    // *****
    always @(negedge mclk) begin
        if (rst_b && ee_busy === 1'b1) begin
            check_word("ee_supply", 16'h0001, {15'h0000, supply});
        end
        if (rst_b && ee_busy === 1'b0) begin
            check_word("ee_clk_idle", 16'h0001, {15'h0000, scl});
        end
        if (rst_b && d_oe_b === 1'b0) begin
            check_word("ee_drive_low", 16'h0000, {15'h0000, d_out});
        end
        cycles++;
        if (cycles == 100000) begin
            bad_count++;
            end_sim();
        end
    end

    // *****
    // Main sequence
    // *****
    initial begin
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        read_cmd(CMD_PACK_STATUS, {PACK_CONFIG_RESET, STATUS_RESET}, 1'b1);
        read_cmd(8'h30, 16'h0000, 1'b0);
        // Clock enable low holds the answer one more cycle
        @(posedge mclk);
        cmd_valid <= 1'b1;
        cmd_code <= CMD_PACK_STATUS;
        @(posedge mclk);
        cmd_valid <= 1'b0;
        ce <= 1'b0;
        @(posedge mclk);
        ce <= 1'b1;
        #1;
        check_word("resp_held", 16'h0001, {15'h0000, resp_valid});
        check_word("resp_held_data", {PACK_CONFIG_RESET, STATUS_RESET}, resp_data);
        meas(16'h1388, 16'h07D0, 16'h07D0, 8'h39, 8'h38);
        meas(16'h0FA0, 16'h07D0, 16'h0578, 8'h85, 8'hC5);
        meas(16'h0FA0, 16'h07D0, 16'h0578, 8'h06, 8'hC6);
        meas(16'h2329, 16'h07D0, 16'h0578, 8'h04, 8'h86);
        meas(16'h1388, 16'h0BB9, 16'h05DC, 8'h05, 8'h86);
        meas(16'h1388, 16'h0BB8, 16'h05DC, 8'h85, 8'h84);
        for (int i = 0; i < 4; i++) begin
            read_cmd(CMD_CELL_FOUR + 8'(i), cells[3 - i], 1'b1);
        end
        @(posedge mclk);
        full_reset_req <= 1'b1;
        @(posedge mclk);
        full_reset_req <= 1'b0;
        wait_idle();
        cfg_exp = 8'hA5;
        read_cmd(CMD_PACK_STATUS, {8'hA5, 8'h84}, 1'b1);
        ee_write(8'h10, 8'h5A, 1'b0);
        check_word("ee_mem", 16'h005A, {8'h00, u_ee_partner_model.mem[8'h10]});
        ee_write(8'h11, 8'hC3, 1'b1);
        check_word("ee_mem_nak", 16'h0000, {8'h00, u_ee_partner_model.mem[8'h11]});
        end_sim();
    end
endmodule : tb
`default_nettype wire
